/* hdl/see_front_end.v */
// serial eeprom front end: pin sampling, decoder, array and programming timer
`default_nettype none
`include "see_map.vh"
module see_front_end #(
   parameter [22:0] PROG_CYCLES = `SEE_PROG_CYCLES
) (
   input wire clk,
   input wire sys_rst,
   input wire supply_ok,
   input wire sel_pin,
   input wire sclk_pin,
   input wire sdi_pin,
   input wire width_select,
   output reg sdo_o,
   output reg sdo_oe_n,
   output wire busy
);
   // ************************************
   // pin synchronisers
   // ************************************
   reg [2:0] sel_s_r, clk_s_r, din_s_r, org_s_r, por_s_r;
   always @(posedge clk) begin
      if (sys_rst) begin
         sel_s_r <= 3'h0;
         clk_s_r <= 3'h0;
         din_s_r <= 3'h0;
         org_s_r <= 3'h7;
         por_s_r <= 3'h0;
      end else begin
         sel_s_r <= {sel_s_r[1:0], sel_pin};
         clk_s_r <= {clk_s_r[1:0], sclk_pin};
         din_s_r <= {din_s_r[1:0], sdi_pin};
         org_s_r <= {org_s_r[1:0], width_select};
         por_s_r <= {por_s_r[1:0], supply_ok};
      end
   end
   reg sel_r, sck_r, din_r, org_r, pok_r;
   always @(posedge clk) begin
      if (sys_rst) begin
         sel_r <= 1'b0;
         sck_r <= 1'b0;
         din_r <= 1'b0;
         org_r <= 1'b1;
         pok_r <= 1'b0;
      end else begin
         if (sel_s_r[1] == sel_s_r[2]) sel_r <= sel_s_r[2];
         if (clk_s_r[1] == clk_s_r[2]) sck_r <= clk_s_r[2];
         if (din_s_r[1] == din_s_r[2]) din_r <= din_s_r[2];
         if (org_s_r[1] == org_s_r[2]) org_r <= org_s_r[2];
         if (por_s_r[1] == por_s_r[2]) pok_r <= por_s_r[2];
      end
   end
   wire sck_rise = clk_s_r[1] & clk_s_r[2] & ~sck_r;
   wire active = sel_r & pok_r;
   wire word_mode = org_r;
   // ************************************
   // array and two-entry program buffer
   // ************************************
   reg [7:0] mem [0:`SEE_DEPTH_BYTES-1];
   function [10:0] byte_addr;
      input [10:0] a;
      input wm;
      input hi;
      begin
         byte_addr = wm ? {a[9:0], hi} : a;
      end
   endfunction
   function [10:0] addr_max;
      input wm;
      begin
         addr_max = wm ? 11'h3FF : 11'h7FF;
      end
   endfunction
   // buffer entries: kind, address, data
   reg [1:0] bk_r [0:1];
   reg [10:0] ba_r [0:1];
   reg [15:0] bd_r [0:1];
   reg bw_r [0:1];
   reg [1:0] bcnt_r;
   reg bwp_r, brp_r;
   wire buf_ready = (bcnt_r != 2'h2);
   wire buf_valid = (bcnt_r != 2'h0);
   // ************************************
   // serial state machine
   // ************************************
   localparam [4:0] ST_HUNT = 5'h01;
   localparam [4:0] ST_OP = 5'h02;
   localparam [4:0] ST_ADDR = 5'h04;
   localparam [4:0] ST_DATA = 5'h08;
   localparam [4:0] ST_READ = 5'h10;
   reg [4:0] st_r;
   reg [4:0] cnt_r;
   reg [1:0] op_r;
   reg [10:0] addr_r;
   reg [15:0] sh_r;
   reg wen_r;
   reg push;
   reg [1:0] push_k;
   reg [15:0] push_d;
   reg [10:0] push_a;
   wire [4:0] alen = word_mode ? 5'd10 : 5'd11;
   wire [4:0] dlen = word_mode ? 5'd16 : 5'd8;
   wire [10:0] addr_full = {addr_r[9:0], din_r};
   wire [1:0] ext_q = word_mode ? addr_full[9:8] : addr_full[10:9];
   wire [15:0] rd_word = word_mode ?
      {mem[byte_addr(addr_r, 1'b1, 1'b1)], mem[byte_addr(addr_r, 1'b1, 1'b0)]} :
      {mem[addr_r], 8'h00};
   always @* begin
      push = 1'b0;
      push_k = op_r;
      push_d = sh_r;
      push_a = addr_r;
      if (active && sck_rise && buf_ready && wen_r) begin
         if (st_r == ST_ADDR && cnt_r == 5'd1) begin
            push_a = addr_full;
            if (op_r == `SEE_OP_ERASE) push = 1'b1;
            if (op_r == `SEE_OP_EXT && ext_q == `SEE_EXT_ERAL) push = 1'b1;
            push_d = 16'hFFFF;
         end
         if (st_r == ST_DATA && cnt_r == 5'd1) begin
            push = 1'b1;
            push_d = word_mode ? {sh_r[14:0], din_r} : {8'h00, sh_r[6:0], din_r};
         end
      end
   end
   always @(posedge clk) begin
      if (sys_rst || !active) begin
         st_r <= ST_HUNT;
         cnt_r <= 5'd0;
         op_r <= 2'h0;
         addr_r <= 11'h000;
         sh_r <= 16'h0000;
         sdo_o <= 1'b0;
         if (sys_rst || !pok_r) wen_r <= 1'b0;
      end else if (sck_rise) begin
         case (st_r)
            ST_HUNT: if (din_r) begin
               st_r <= ST_OP;
               addr_r <= 11'h000;
               cnt_r <= 5'd2;
            end
            ST_OP: begin
               op_r <= {op_r[0], din_r};
               cnt_r <= cnt_r - 5'd1;
               if (cnt_r == 5'd1) begin
                  st_r <= ST_ADDR;
                  cnt_r <= alen;
               end
            end
            ST_ADDR: begin
               addr_r <= addr_full;
               cnt_r <= cnt_r - 5'd1;
               if (cnt_r == 5'd1) begin
                  case (op_r)
                     `SEE_OP_READ: begin
                        st_r <= ST_READ;
                        sh_r <= rd_word;
                        cnt_r <= dlen;
                        sdo_o <= 1'b0;
                     end
                     `SEE_OP_WRITE: begin
                        st_r <= ST_DATA;
                        cnt_r <= dlen;
                     end
                     `SEE_OP_EXT: begin
                        if (ext_q == `SEE_EXT_EN) wen_r <= 1'b1;
                        if (ext_q == `SEE_EXT_DIS) wen_r <= 1'b0;
                        if (ext_q == `SEE_EXT_WRAL) begin
                           st_r <= ST_DATA;
                           cnt_r <= dlen;
                        end else begin
                           st_r <= ST_HUNT;
                        end
                     end
                     default: st_r <= ST_HUNT;
                  endcase
               end
            end
            ST_DATA: begin
               sh_r <= {sh_r[14:0], din_r};
               cnt_r <= cnt_r - 5'd1;
               if (cnt_r == 5'd1) st_r <= ST_HUNT;
            end
            ST_READ: begin
               sdo_o <= sh_r[15];
               sh_r <= {sh_r[14:0], 1'b0};
               cnt_r <= cnt_r - 5'd1;
               if (cnt_r == 5'd1) begin
                  addr_r <= (addr_r == addr_max(word_mode)) ? 11'h000 : addr_r + 11'h001;
                  cnt_r <= dlen;
               end
            end
            default: st_r <= ST_HUNT;
         endcase
      end else if (st_r == ST_READ && cnt_r == dlen) begin
         sh_r <= rd_word;
      end
   end
   always @(posedge clk) begin
      if (sys_rst) sdo_oe_n <= 1'b1;
      else sdo_oe_n <= ~active;
   end
   // ************************************
   // self-timed programming engine
   // ************************************
   reg [22:0] tmr_r;
   reg prog_r;
   reg [10:0] wa_r;
   wire [1:0] hk = bk_r[brp_r];
   wire [10:0] ha = ba_r[brp_r];
   wire [15:0] hd = bd_r[brp_r];
   wire hw = bw_r[brp_r];
   wire fill_all = (hk == `SEE_OP_EXT);
   // fill ops hold busy until the last byte is written
   wire pop = prog_r && (tmr_r >= PROG_CYCLES - 23'd1) && (!fill_all || wa_r == 11'h7FF);
   always @(posedge clk) begin
      if (sys_rst) begin
         bcnt_r <= 2'h0;
         bwp_r <= 1'b0;
         brp_r <= 1'b0;
         tmr_r <= 23'd0;
         prog_r <= 1'b0;
         wa_r <= 11'h000;
      end else begin
         if (push) begin
            bk_r[bwp_r] <= push_k;
            ba_r[bwp_r] <= push_a;
            bd_r[bwp_r] <= push_d;
            bw_r[bwp_r] <= word_mode;
            bwp_r <= ~bwp_r;
         end
         bcnt_r <= bcnt_r + {1'b0, push} - {1'b0, pop};
         if (buf_valid && !prog_r) begin
            prog_r <= 1'b1;
            tmr_r <= 23'd0;
            wa_r <= 11'h000;
         end else if (prog_r) begin
            if (fill_all) begin
               mem[wa_r] <= hw ? (wa_r[0] ? hd[15:8] : hd[7:0]) : hd[7:0];
               if (wa_r != 11'h7FF) wa_r <= wa_r + 11'h001;
            end else if (tmr_r == 23'd0) begin
               if (hw) begin
                  mem[byte_addr(ha, 1'b1, 1'b1)] <= hd[15:8];
                  mem[byte_addr(ha, 1'b1, 1'b0)] <= hd[7:0];
               end else begin
                  mem[ha] <= hd[7:0];
               end
            end
            tmr_r <= tmr_r + 23'd1;
            if (pop) begin
               prog_r <= 1'b0;
               brp_r <= ~brp_r;
            end
         end
      end
   end
   assign busy = prog_r | buf_valid;
endmodule // see_front_end
`default_nettype wire

/* hdl/see_map.vh */
// constants of the serial eeprom front end
`ifndef SEE_MAP_VH
`define SEE_MAP_VH
`define SEE_CLK_HZ 40000000
`define SEE_PROG_TIME_US 5000
// 5 ms at 40 MHz
`define SEE_PROG_CYCLES 23'd200000
`define SEE_ADDR_W 11
`define SEE_DEPTH_BYTES 2048
`define SEE_DEPTH_WORDS 1024
`define SEE_OP_READ 2'h2
`define SEE_OP_WRITE 2'h1
`define SEE_OP_ERASE 2'h3
`define SEE_OP_EXT 2'h0
`define SEE_EXT_EN 2'h3
`define SEE_EXT_DIS 2'h0
`define SEE_EXT_ERAL 2'h2
`define SEE_EXT_WRAL 2'h1
`define SEE_ERASED 8'hFF
`endif

/* dv/see_chk.sv */
// pin level checks on the eeprom front end
`default_nettype none
module see_chk #(
   parameter [22:0] PROG_CYCLES = 23'd50
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic supply_ok,
   input wire logic sel_pin,
   input wire logic sclk_pin,
   input wire logic sdi_pin,
   input wire logic width_select,
   input wire logic sdo_o,
   input wire logic sdo_oe_n,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sclk_r;
   logic [3:0] age_r;
   logic [22:0] run_r;
   // cycles since a raw serial clock rise, length of busy run
   always @(posedge clk) begin
      sclk_r <= sclk_pin;
      age_r <= (sys_rst || (sclk_pin && !sclk_r)) ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
      run_r <= (busy && !sys_rst) ? run_r + 23'h1 : 23'h0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence sel_idle; !sel_pin [*6]; endsequence
   sequence pwr_gone; !supply_ok [*6]; endsequence
   oe_idle_a: assert property (sel_idle |-> sdo_oe_n) else $error("driven when idle");
   oe_power_a: assert property (pwr_gone |-> sdo_oe_n) else $error("driven unpowered");
   rst_state_a: assert property ($past(sys_rst) |-> sdo_oe_n && !busy) else $error("reset");
   busy_len_a: assert property ($fell(busy) |-> run_r >= PROG_CYCLES) else $error("short");
   busy_cause_a: assert property ($rose(busy) |-> $past(supply_ok, 6)) else $error("pwr");
   idle_prog_a: assert property (sel_idle |-> !$rose(busy)) else $error("busy idle");
   dummy_zero_a: assert property ($fell(sdo_oe_n) |-> !sdo_o) else $error("dummy");
   sdo_edge_a: assert property (!sdo_oe_n && !$past(sdo_oe_n) && $changed(sdo_o)
      |-> age_r >= 4'h2 && age_r <= 4'h8) else $error("sdo moved off edge");
endmodule // see_chk
`default_nettype wire

/* dv/see_master.sv */
// serial bus master model
`default_nettype none
module see_master (
   input wire logic clk,
   input wire logic sdo_line,
   output var logic sel_pin,
   output var logic sclk_pin,
   output var logic sdi_pin,
   output var logic smp_stb,
   output var logic smp_val
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sel_pin = 1'b0;
      sclk_pin = 1'b0;
      sdi_pin = 1'b0;
      smp_stb = 1'b0;
      smp_val = 1'b0;
   end
   // n command bits msb first, then r sampled bits
   task automatic frame(input logic [31:0] c, input int n, input int r);
      int i;
      sel_pin <= 1'b1;
      repeat (4) @(negedge clk);
      for (i = 0; i < n + r; i++) begin
         sdi_pin <= (i < n) ? c[n - 1 - i] : ~sdi_pin;
         repeat (4) @(negedge clk);
         smp_val <= sdo_line;
         smp_stb <= (i >= n);
         // 200 ns period, above the bus limit on purpose to stress the pin sampler
         sclk_pin <= 1'b1;
         repeat (4) @(negedge clk);
         smp_stb <= 1'b0;
         sclk_pin <= 1'b0;
      end
      repeat (4) @(negedge clk);
      sel_pin <= 1'b0;
      sdi_pin <= ~sdi_pin;
      repeat (8) @(negedge clk);
   endtask
endmodule // see_master
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench of the eeprom front end
`default_nettype none
`include "see_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic supply_ok = 1'b1;
   logic width_select = 1'b0;
   wire sel_pin, sclk_pin, sdi_pin, sdo_o, sdo_oe_n, busy, sdo_line, smp_stb, smp_val;
   logic exp_q[$];
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [7:0] d1, d2, d3;
   always #12.5 clk = ~clk;
   assign sdo_line = sdo_oe_n ? 1'bz : sdo_o;
   see_front_end #(.PROG_CYCLES(23'd50)) see_front_end_i (.clk(clk), .sys_rst(sys_rst),
      .supply_ok(supply_ok), .sel_pin(sel_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
      .width_select(width_select), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .busy(busy));
   see_master see_master_i (.clk(clk), .sdo_line(sdo_line), .sel_pin(sel_pin),
      .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .smp_stb(smp_stb), .smp_val(smp_val));
   task check(input string nm, input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge smp_stb) if (exp_q.size() > 0) check("sdo", smp_val, exp_q.pop_front());
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         tally_and_finish();
      end
   end
   function logic [31:0] bc(input logic [1:0] op, input logic [10:0] a);
      bc = {18'h0, 1'b1, op, a};
   endfunction
   task prog(input logic [31:0] c, input int n, input logic acc);
      see_master_i.frame(c, n, 0);
      check("busy", busy, acc);
   endtask
   task idle;
      int i;
      for (i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clk);
      check("busy", busy, 1'b0);
   endtask
   task rd(input logic [31:0] c, input int n, input int w, input logic [31:0] e);
      int i;
      exp_q.push_back(1'b0);
      for (i = w - 1; i >= 0; i--) exp_q.push_back(e[i]);
      see_master_i.frame(c, n, w + 1);
   endtask
   // ***********
   // main sequence
   // ***********
   initial begin
      void'($urandom(36566));
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      d3 = 8'($urandom);
      repeat (2) @(negedge clk);
      sys_rst <= 1'b0;
      repeat (8) @(negedge clk);
      check("oe_n", sdo_oe_n, 1'b1);
      supply_ok <= 1'b0;
      repeat (8) @(negedge clk);
      prog(bc(`SEE_OP_EXT, 11'h600), 14, 1'b0);
      prog((bc(`SEE_OP_EXT, 11'h200) << 8) | d1, 22, 1'b0);
      supply_ok <= 1'b1;
      repeat (8) @(negedge clk);
      prog((bc(`SEE_OP_WRITE, 11'h005) << 8) | d1, 22, 1'b0);
      prog(bc(`SEE_OP_EXT, 11'h600), 14, 1'b0);
      prog((bc(`SEE_OP_EXT, 11'h200) << 8) | d1, 22, 1'b1);
      idle();
      prog((bc(`SEE_OP_WRITE, 11'h7FF) << 8) | d2, 22, 1'b1);
      prog((bc(`SEE_OP_WRITE, 11'h000) << 8) | d3, 22, 1'b1);
      idle();
      rd(bc(`SEE_OP_READ, 11'h7FE), 14, 24, {8'h0, d1, d2, d3});
      width_select <= 1'b1;
      repeat (8) @(negedge clk);
      rd({19'h0, 1'b1, `SEE_OP_READ, 10'h3FF}, 13, 32, {d2, d1, d1, d3});
      width_select <= 1'b0;
      repeat (8) @(negedge clk);
      prog(bc(`SEE_OP_ERASE, 11'h000), 14, 1'b1);
      idle();
      rd(bc(`SEE_OP_READ, 11'h000), 14, 8, {24'h0, `SEE_ERASED});
      prog(bc(`SEE_OP_EXT, 11'h000), 14, 1'b0);
      prog((bc(`SEE_OP_WRITE, 11'h001) << 8) | d2, 22, 1'b0);
      prog(bc(`SEE_OP_EXT, 11'h600), 14, 1'b0);
      prog(bc(`SEE_OP_EXT, 11'h400), 14, 1'b1);
      idle();
      rd(bc(`SEE_OP_READ, 11'h7FF), 14, 16, {16'h0, `SEE_ERASED, `SEE_ERASED});
      prog(bc(`SEE_OP_EXT, 11'h000), 14, 1'b0);
      prog((bc(`SEE_OP_EXT, 11'h200) << 8) | d1, 22, 1'b0);
      prog(bc(`SEE_OP_EXT, 11'h600), 14, 1'b0);
      prog((bc(`SEE_OP_EXT, 11'h200) << 8) | d1, 22, 1'b1);
      sys_rst <= 1'b1;
      repeat (2) @(negedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(negedge clk);
      check("busy", busy, 1'b0);
      prog((bc(`SEE_OP_WRITE, 11'h003) << 8) | d3, 22, 1'b0);
      check("notes_left", exp_q.size() == 0, 1'b1);
      tally_and_finish();
   end
endmodule // tb_top
bind see_front_end see_chk #(.PROG_CYCLES(PROG_CYCLES)) see_chk_i (.clk(clk), .sys_rst(sys_rst),
   .supply_ok(supply_ok), .sel_pin(sel_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
   .width_select(width_select), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .busy(busy));
`default_nettype wire
